// ---- dv/mcpt_ext_model.sv ----
`timescale 1ns/10ps
module mcpt_ext_model (
  input wire logic sys_clk,
  input wire logic [3:0] out_p,
  input wire logic [2:0] out_n,
  output logic [3:0] ch_in,
  output logic trig_in,
  output logic shoot
);
  int ph = 0;
  initial begin
    ch_in = 4'h0;
    trig_in = 1'b0;
    shoot = 1'b0;
  end
  always @(posedge sys_clk) begin
    if ((out_p[2:0] & out_n) !== 3'h0) shoot <= 1'b1;
  end
  // gray steps, spaced for the input sync
  task automatic enc(input int steps, input int dir);
    repeat (steps) begin
      @(posedge sys_clk);
      ph = (ph + dir + 4) % 4;
      ch_in[0] <= (ph == 1) || (ph == 2);
      ch_in[1] <= (ph >= 2);
      repeat (4) @(posedge sys_clk);
    end
  endtask : enc
  // one edge on a capture pin
  task automatic edge_in(input int k, input logic lvl);
    @(posedge sys_clk);
    ch_in[k] <= lvl;
  endtask : edge_in
  // pulse long enough to pass the sync
  task automatic pulse_trig();
    @(posedge sys_clk);
    trig_in <= 1'b1;
    repeat (2) @(posedge sys_clk);
    trig_in <= 1'b0;
  endtask : pulse_trig
endmodule : mcpt_ext_model

// ---- dv/test_multi_channel_capture_pwm_timer.sv ----
`timescale 1ns/10ps
`define chk(a, e, m) begin n_compared++; if ((a) !== (e)) begin fails++; \
  $display("CHECK FAILED t=%0t %s", $time, m); end end
module test_multi_channel_capture_pwm_timer;
  typedef struct packed {logic [7:0] addr; logic [31:0] data; logic [1:0] resp;} mcpt_row_t;
  logic sys_clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, c1;
  logic [3:0] s_axi_wstrb, ch_in, out_p;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, last_resp;
  logic trig_in, dbg_halt, trig_out, irq, shoot, e;
  logic [2:0] out_n;
  logic [4:0] dma_req;
  int fails = 0, n_compared = 0, cyc = 0, n, bad;
  // unmapped and misaligned places answer with an error
  mcpt_row_t rows [0:11] = '{'{mcpt_pkg::OFS_CTRL, 32'h0, 2'h0}, '{mcpt_pkg::OFS_PSC, 32'h0, 2'h0},
    '{mcpt_pkg::OFS_ARR, mcpt_pkg::ARR_RST, 2'h0}, '{mcpt_pkg::OFS_CNT, 32'h0, 2'h0},
    '{mcpt_pkg::OFS_CCMODE, 32'h0, 2'h0}, '{mcpt_pkg::OFS_DEADT, 32'h0, 2'h0},
    '{mcpt_pkg::OFS_STATUS, 32'h0, 2'h0}, '{mcpt_pkg::OFS_MASK, 32'h0, 2'h0},
    '{mcpt_pkg::OFS_CCR0, 32'h0, 2'h0}, '{mcpt_pkg::OFS_DMAEN, 32'h0, 2'h0},
    '{8'h40, 32'h0, mcpt_pkg::RESP_SLVERR}, '{8'h02, 32'h0, mcpt_pkg::RESP_SLVERR}};
  mcpt_timer #(.KIND(mcpt_pkg::KIND_ADV)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .ch_in(ch_in), .trig_in(trig_in),
    .dbg_halt(dbg_halt), .out_p(out_p), .out_n(out_n), .trig_out(trig_out), .dma_req(dma_req),
    .irq(irq));
  mcpt_ext_model u_ext (.sys_clk(sys_clk), .out_p(out_p), .out_n(out_n), .ch_in(ch_in),
    .trig_in(trig_in), .shoot(shoot));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  // ceiling well above the few hundred cycles the tests need
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    last_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  // cycles between two update pulses on trig_out
  task automatic upd_gap(output int g);
    g = 0;
    do @(posedge sys_clk); while (trig_out !== 1'b1 && g++ < 100);
    g = 0;
    do begin @(posedge sys_clk); g++; end while (trig_out !== 1'b1 && g < 100);
  endtask : upd_gap
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    last_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    dbg_halt = 1'b0;
    rst_n = 1'b0;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    for (int i = 0; i < 12; i++) begin
      rd(rows[i].addr, d);
      `chk(d, rows[i].data, "reset value")
      `chk(last_resp, rows[i].resp, "read response")
    end
    wr(8'h40, 32'h5);
    `chk(last_resp, mcpt_pkg::RESP_SLVERR, "unmapped write")
    $display("test registers done");
    wr(mcpt_pkg::OFS_PSC, 32'h1);
    wr(mcpt_pkg::OFS_ARR, 32'h3);
    wr(mcpt_pkg::OFS_DMAEN, 32'h1);
    wr(mcpt_pkg::OFS_CTRL, 32'h1);
    upd_gap(n);
    `chk(n, 8, "update period")
    `chk(dma_req[0], 1'b1, "update dma request")
    wr(mcpt_pkg::OFS_CTRL, 32'h0);
    rd(mcpt_pkg::OFS_STATUS, d);
    `chk(d[mcpt_pkg::STAT_UIF], 1'b1, "update flag")
    `chk(irq, 1'b0, "masked irq")
    wr(mcpt_pkg::OFS_MASK, 32'h1);
    repeat (2) @(posedge sys_clk);
    `chk(irq, 1'b1, "unmasked irq")
    wr(mcpt_pkg::OFS_STATUS, 32'h1);
    repeat (2) @(posedge sys_clk);
    `chk(irq, 1'b0, "cleared irq")
    wr(mcpt_pkg::OFS_CNT, 32'h0);
    wr(mcpt_pkg::OFS_CTRL, 32'h11);
    repeat (40) @(posedge sys_clk);
    rd(mcpt_pkg::OFS_CTRL, d);
    `chk(d[mcpt_pkg::CTRL_EN], 1'b0, "one pulse stop")
    $display("test update done");
    wr(mcpt_pkg::OFS_CNT, 32'h1234);
    wr(mcpt_pkg::OFS_CCMODE, {30'h0, mcpt_pkg::CCM_CAPT});
    u_ext.edge_in(0, 1'b1);
    repeat (8) @(posedge sys_clk);
    rd(mcpt_pkg::OFS_CCR0, d);
    `chk(d, 32'h1234, "captured count")
    rd(mcpt_pkg::OFS_STATUS, d);
    `chk(d[mcpt_pkg::STAT_CC0], 1'b1, "capture flag")
    u_ext.edge_in(0, 1'b0);
    $display("test capture done");
    wr(mcpt_pkg::OFS_ARR, 32'h9);
    wr(mcpt_pkg::OFS_PSC, 32'h0);
    // the captured count sits above the new reload, start the period from zero
    wr(mcpt_pkg::OFS_CNT, 32'h0);
    wr(mcpt_pkg::OFS_CCMODE, {30'h0, mcpt_pkg::CCM_PWM});
    // duty 0 and duty above reload: no edges, no dead time
    for (int k = 0; k < 2; k++) begin
      e = (k == 1);
      wr(mcpt_pkg::OFS_CCR0, k * 10);
      wr(mcpt_pkg::OFS_CTRL, 32'h1);
      repeat (20) @(posedge sys_clk);
      bad = 0;
      repeat (30) begin
        @(posedge sys_clk);
        if (out_p[0] !== e || out_n[0] !== !e) bad++;
      end
      `chk(bad, 0, "full range duty")
    end
    wr(mcpt_pkg::OFS_DEADT, 32'h3);
    wr(mcpt_pkg::OFS_CCR0, 32'h5);
    n = 0;
    do @(posedge sys_clk); while (out_n[0] !== 1'b1 && n++ < 100);
    do @(posedge sys_clk); while (out_n[0] !== 1'b0 && n++ < 100);
    n = 0;
    while (out_p[0] === 1'b0 && n < 50) begin
      n++;
      @(posedge sys_clk);
    end
    `chk(n, 4, "dead time gap")
    $display("test pwm done");
    wr(mcpt_pkg::OFS_CTRL, 32'h21);
    @(posedge sys_clk);
    dbg_halt <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rd(mcpt_pkg::OFS_CNT, c1);
    repeat (10) @(posedge sys_clk);
    rd(mcpt_pkg::OFS_CNT, d);
    `chk(d, c1, "frozen count")
    `chk({out_p, out_n}, 7'h00, "outputs off in debug")
    dbg_halt <= 1'b0;
    $display("test debug done");
    // down count reloads every reload plus one, center mode updates at top and zero
    wr(mcpt_pkg::OFS_ARR, 32'h5);
    for (int k = 0; k < 2; k++) begin
      wr(mcpt_pkg::OFS_CTRL, 32'h0);
      wr(mcpt_pkg::OFS_CNT, 32'h0);
      wr(mcpt_pkg::OFS_CTRL, k ? 32'h5 : 32'h3);
      upd_gap(n);
      `chk(n, k ? 5 : 6, "down and center period")
    end
    $display("test direction done");
    wr(mcpt_pkg::OFS_CTRL, 32'h0);
    wr(mcpt_pkg::OFS_ARR, 32'hffff);
    wr(mcpt_pkg::OFS_CNT, 32'h0);
    wr(mcpt_pkg::OFS_CTRL, 32'h41);
    u_ext.enc(4, 1);
    rd(mcpt_pkg::OFS_CNT, d);
    `chk(d, 32'h4, "encoder forward")
    u_ext.enc(2, -1);
    rd(mcpt_pkg::OFS_CNT, d);
    `chk(d, 32'h2, "encoder reverse")
    $display("test encoder done");
    wr(mcpt_pkg::OFS_CTRL, 32'h0);
    wr(mcpt_pkg::OFS_PSC, 32'hffff);
    wr(mcpt_pkg::OFS_CNT, 32'h50);
    wr(mcpt_pkg::OFS_CTRL, 32'h81);
    u_ext.pulse_trig();
    repeat (6) @(posedge sys_clk);
    rd(mcpt_pkg::OFS_CNT, d);
    `chk(d, 32'h0, "link reset")
    wr(mcpt_pkg::OFS_CTRL, 32'h180);
    u_ext.pulse_trig();
    repeat (6) @(posedge sys_clk);
    rd(mcpt_pkg::OFS_CTRL, d);
    `chk(d[mcpt_pkg::CTRL_EN], 1'b1, "trigger start")
    `chk(shoot, 1'b0, "no overlap of pair")
    $display("test link done");
    summarize();
  end
endmodule : test_multi_channel_capture_pwm_timer

// ---- rtl/mcpt_chan.sv ----
`timescale 1ns/10ps
module mcpt_chan (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic active,
  input wire logic [1:0] mode,
  input wire logic pol,
  input wire logic [31:0] cnt,
  input wire logic moved,
  input wire logic in_lvl,
  input wire logic wr_ccr,
  input wire logic [31:0] wdata,
  output logic [31:0] ccr,
  output logic oc,
  output logic ev
);
  logic in_prev;
  wire edge_seen = pol ? (in_prev & ~in_lvl) : (~in_prev & in_lvl);
  wire cap = active && (mode == mcpt_pkg::CCM_CAPT) && edge_seen;
  wire is_out = active && ((mode == mcpt_pkg::CCM_TOGGLE) || (mode == mcpt_pkg::CCM_PWM));
  wire match = is_out && moved && (cnt == ccr);
  // full duty range
  // cnt below ccr gives 0 % at ccr 0 and 100 % once ccr passes the reload value
  wire pwm_lvl = (cnt < ccr) ^ pol;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_prev <= 1'b0;
      ccr <= mcpt_pkg::ZERO_RST;
      oc <= 1'b0;
      ev <= 1'b0;
    end else begin
      in_prev <= in_lvl;
      ev <= cap | match;
      if (cap) begin
        ccr <= cnt;
      end else if (wr_ccr) begin
        ccr <= wdata;
      end
      if (!is_out) begin
        oc <= 1'b0;
      end else if (mode == mcpt_pkg::CCM_PWM) begin
        oc <= pwm_lvl;
      end else if (match) begin
        oc <= ~oc;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  capture_latch_a: assert property (cap |=> ccr == $past(cnt) && ev)
    else $error("capture did not latch counter");
  pwm_zero_a: assert property (active && mode == mcpt_pkg::CCM_PWM && ccr == 32'h0
      ##1 $stable(mode) && $stable(pol) |-> oc == pol)
    else $error("pwm with zero duty not off");

endmodule : mcpt_chan

// ---- rtl/mcpt_pkg.sv ----
package mcpt_pkg;

  typedef enum logic [2:0] {
    KIND_ADV = 3'h0,
    KIND_WIDE = 3'h1,
    KIND_STD = 3'h2,
    KIND_SINGLE = 3'h3,
    KIND_TWO = 3'h4,
    KIND_ONE_COMP = 3'h5,
    KIND_BASIC = 3'h6
  } mcpt_kind_t;

  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PSC = 8'h04;
  localparam logic [7:0] OFS_ARR = 8'h08;
  localparam logic [7:0] OFS_CNT = 8'h0c;
  localparam logic [7:0] OFS_CCMODE = 8'h10;
  localparam logic [7:0] OFS_DEADT = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_MASK = 8'h1c;
  localparam logic [7:0] OFS_CCR0 = 8'h20;
  localparam logic [7:0] OFS_DMAEN = 8'h30;

  localparam int CTRL_W = 9;
  localparam int CTRL_EN = 0;
  localparam int CTRL_DIR = 1;
  localparam int CTRL_CMS = 2;
  localparam int CTRL_OPM = 4;
  localparam int CTRL_DBGF = 5;
  localparam int CTRL_ENC = 6;
  localparam int CTRL_SMS = 7;

  localparam int CCM_W = 3;
  localparam int CCM_POL = 2;
  localparam logic [1:0] CCM_OFF = 2'h0;
  localparam logic [1:0] CCM_TOGGLE = 2'h1;
  localparam logic [1:0] CCM_PWM = 2'h2;
  localparam logic [1:0] CCM_CAPT = 2'h3;

  localparam logic [1:0] SMS_OFF = 2'h0;
  localparam logic [1:0] SMS_RESET = 2'h1;
  localparam logic [1:0] SMS_GATED = 2'h2;
  localparam logic [1:0] SMS_TRIG = 2'h3;

  localparam int STAT_W = 5;
  localparam int STAT_UIF = 0;
  localparam int STAT_CC0 = 1;

  localparam logic [31:0] ARR_RST = 32'hffffffff;
  localparam logic [31:0] ZERO_RST = 32'h00000000;
  localparam logic [31:0] MASK_32 = 32'hffffffff;
  localparam logic [31:0] MASK_16 = 32'h0000ffff;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : mcpt_pkg

// ---- rtl/mcpt_timer.sv ----
// Implementation choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
module mcpt_timer #(
  parameter mcpt_pkg::mcpt_kind_t KIND = mcpt_pkg::KIND_ADV
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] ch_in,
  input wire logic trig_in,
  input wire logic dbg_halt,
  output logic [3:0] out_p,
  output logic [2:0] out_n,
  output logic trig_out,
  output logic [4:0] dma_req,
  output logic irq
);
  localparam logic [31:0] CMASK = (KIND == mcpt_pkg::KIND_WIDE) ? mcpt_pkg::MASK_32
                                                               : mcpt_pkg::MASK_16;
  localparam bit FULL = (KIND == mcpt_pkg::KIND_ADV) || (KIND == mcpt_pkg::KIND_WIDE) ||
                        (KIND == mcpt_pkg::KIND_STD);
  // single channel, two channels, basic has none
  localparam int NCH = FULL ? 4 : (KIND == mcpt_pkg::KIND_TWO) ? 2 :
                       (KIND == mcpt_pkg::KIND_BASIC) ? 0 : 1;
  // three complementary pairs on the advanced timer
  localparam int NCOMP = (KIND == mcpt_pkg::KIND_ADV) ? 3 :
                         ((KIND == mcpt_pkg::KIND_TWO) || (KIND == mcpt_pkg::KIND_ONE_COMP)) ? 1
                                                                                        : 0;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b+:8] = nw[8*b+:8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic is_mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= mcpt_pkg::OFS_DMAEN);
  endfunction : is_mapped

  // two-flop synchronisers for every pin
  logic [3:0] ch_s1, ch_s2, enc_prev;
  logic trig_s1, trig_s2, trig_prev, halt_s1, halt_s2;

  logic [mcpt_pkg::CTRL_W-1:0] ctrl;
  logic [15:0] psc, psc_cnt;
  logic [31:0] arr, cnt, next_cnt;
  logic [4*mcpt_pkg::CCM_W-1:0] ccmode;
  logic [7:0] deadt;
  logic [mcpt_pkg::STAT_W-1:0] status, mask, dmaen, next_status;
  logic cdir, next_cdir, wrap, moved;
  logic [3:0][31:0] ccr;
  logic [3:0] oc, cc_ev;
  logic [2:0][7:0] dt_cnt;
  logic [2:0] oc_prev;

  // bus slave
  logic aw_hold, w_hold;
  logic [7:0] aw_q;
  logic [31:0] w_q;
  logic [3:0] strb_q;
  wire aw_fire = s_axi_awvalid & s_axi_awready;
  wire w_fire = s_axi_wvalid & s_axi_wready;
  wire wr_go = aw_hold & w_hold & ~s_axi_bvalid;
  wire next_aw_hold = (aw_hold | aw_fire) & ~wr_go;
  wire next_w_hold = (w_hold | w_fire) & ~wr_go;
  wire ar_fire = s_axi_arvalid & s_axi_arready;
  wire next_rvalid = (s_axi_rvalid & ~s_axi_rready) | ar_fire;

  wire wr_ctrl = wr_go && (aw_q == mcpt_pkg::OFS_CTRL);
  wire wr_psc = wr_go && (aw_q == mcpt_pkg::OFS_PSC);
  wire wr_arr = wr_go && (aw_q == mcpt_pkg::OFS_ARR);
  wire wr_cnt = wr_go && (aw_q == mcpt_pkg::OFS_CNT);
  wire wr_ccm = wr_go && (aw_q == mcpt_pkg::OFS_CCMODE);
  wire wr_dt = wr_go && (aw_q == mcpt_pkg::OFS_DEADT);
  wire wr_stat = wr_go && (aw_q == mcpt_pkg::OFS_STATUS);
  wire wr_mask = wr_go && (aw_q == mcpt_pkg::OFS_MASK);
  wire wr_dma = wr_go && (aw_q == mcpt_pkg::OFS_DMAEN);
  wire [31:0] wmerged = merge(32'h0, w_q, strb_q);
  wire [31:0] ctrl_w = merge(32'(ctrl), w_q, strb_q);
  wire [31:0] psc_w = merge(32'(psc), w_q, strb_q);

  wire [7:0] ra = s_axi_araddr;
  wire [31:0] rd_word =
    (ra == mcpt_pkg::OFS_CTRL) ? 32'(ctrl) :
    (ra == mcpt_pkg::OFS_PSC) ? 32'(psc) :
    (ra == mcpt_pkg::OFS_ARR) ? arr :
    (ra == mcpt_pkg::OFS_CNT) ? cnt :
    (ra == mcpt_pkg::OFS_CCMODE) ? 32'(ccmode) :
    (ra == mcpt_pkg::OFS_DEADT) ? 32'(deadt) :
    (ra == mcpt_pkg::OFS_STATUS) ? 32'(status) :
    (ra == mcpt_pkg::OFS_MASK) ? 32'(mask) :
    (ra == mcpt_pkg::OFS_DMAEN) ? 32'(dmaen) :
    (ra[7:4] == 4'h2) ? ccr[ra[3:2]] : 32'h0;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_q <= 8'h0;
      w_q <= 32'h0;
      strb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= mcpt_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= mcpt_pkg::RESP_OKAY;
    end else begin
      aw_hold <= next_aw_hold;
      w_hold <= next_w_hold;
      s_axi_awready <= ~next_aw_hold;
      s_axi_wready <= ~next_w_hold;
      s_axi_arready <= ~next_rvalid;
      s_axi_rvalid <= next_rvalid;
      if (aw_fire) begin
        aw_q <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_q <= s_axi_wdata;
        strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(aw_q) ? mcpt_pkg::RESP_OKAY : mcpt_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (ar_fire) begin
        s_axi_rdata <= is_mapped(ra) ? rd_word : 32'h0;
        s_axi_rresp <= is_mapped(ra) ? mcpt_pkg::RESP_OKAY : mcpt_pkg::RESP_SLVERR;
      end
    end
  end

  // counter control
  wire [1:0] sms = ctrl[mcpt_pkg::CTRL_SMS+:2];
  wire frozen = ctrl[mcpt_pkg::CTRL_DBGF] & halt_s2;
  wire enc_on = FULL && ctrl[mcpt_pkg::CTRL_ENC];
  wire [1:0] cms = FULL ? ctrl[mcpt_pkg::CTRL_CMS+:2] : 2'h0;
  wire trig_rise = trig_s2 & ~trig_prev;
  wire sync_rst = (sms == mcpt_pkg::SMS_RESET) && trig_rise;
  wire gate_ok = (sms != mcpt_pkg::SMS_GATED) || trig_s2;
  wire run = ctrl[mcpt_pkg::CTRL_EN] & ~frozen & gate_ok;
  wire psc_hit = psc_cnt == psc;
  // x4 quadrature decode, phase a leading b counts up
  wire enc_step = (ch_s2[0] ^ enc_prev[0]) | (ch_s2[1] ^ enc_prev[1]);
  wire enc_up = ch_s2[0] ^ enc_prev[1];
  wire step = run & (enc_on ? enc_step : psc_hit);
  wire [31:0] arr_m = arr & CMASK;
  wire at_top = cnt == arr_m;
  wire at_zero = cnt == 32'h0;
  wire down = enc_on ? ~enc_up : (cms != 2'h0) ? cdir : (FULL & ctrl[mcpt_pkg::CTRL_DIR]);
  wire uev = sync_rst | (step & wrap);
  wire [4:0] events = {cc_ev, uev};

  always_comb begin
    next_cnt = cnt;
    next_cdir = cdir;
    wrap = 1'b0;
    if (step) begin
      if (down) begin
        wrap = at_zero;
        next_cnt = at_zero ? ((cms != 2'h0) ? (cnt + 32'h1) & CMASK : arr_m) : cnt - 32'h1;
        next_cdir = at_zero ? 1'b0 : cdir;
      end else begin
        wrap = at_top;
        next_cnt = at_top ? ((cms != 2'h0) ? (cnt - 32'h1) & CMASK : 32'h0)
                          : (cnt + 32'h1) & CMASK;
        next_cdir = at_top ? 1'b1 : cdir;
      end
    end
  end

  // set wins over the write-one clear
  assign next_status = (status & ~(wr_stat ? wmerged[mcpt_pkg::STAT_W-1:0] : 5'h0)) | events;
  // irq sees a mask written in the same cycle, so it never lags the status
  wire [mcpt_pkg::STAT_W-1:0] next_mask = wr_mask ? wmerged[mcpt_pkg::STAT_W-1:0] : mask;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      {ch_s1, ch_s2, enc_prev} <= 12'h0;
      {trig_s1, trig_s2, trig_prev, halt_s1, halt_s2} <= 5'h0;
      ctrl <= '0;
      psc <= 16'h0;
      arr <= mcpt_pkg::ARR_RST;
      ccmode <= '0;
      deadt <= 8'h0;
      mask <= '0;
      dmaen <= '0;
    end else begin
      ch_s1 <= ch_in;
      ch_s2 <= ch_s1;
      enc_prev <= ch_s2;
      trig_s1 <= trig_in;
      trig_s2 <= trig_s1;
      trig_prev <= trig_s2;
      halt_s1 <= dbg_halt;
      halt_s2 <= halt_s1;
      if (wr_ctrl) begin
        ctrl <= ctrl_w[mcpt_pkg::CTRL_W-1:0];
      end else if (uev && ctrl[mcpt_pkg::CTRL_OPM]) begin
        // one-pulse mode stops after one period
        ctrl[mcpt_pkg::CTRL_EN] <= 1'b0;
      end
      if (sms == mcpt_pkg::SMS_TRIG && trig_rise) begin
        ctrl[mcpt_pkg::CTRL_EN] <= 1'b1;
      end
      if (wr_psc) psc <= psc_w[15:0];
      if (wr_arr) arr <= merge(arr, w_q, strb_q);
      if (wr_ccm) ccmode <= wmerged[4*mcpt_pkg::CCM_W-1:0];
      if (wr_dt) deadt <= wmerged[7:0];
      if (wr_mask) mask <= next_mask;
      if (wr_dma) dmaen <= wmerged[mcpt_pkg::STAT_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      psc_cnt <= 16'h0;
      cnt <= mcpt_pkg::ZERO_RST;
      cdir <= 1'b0;
      moved <= 1'b0;
      status <= '0;
      irq <= 1'b0;
      dma_req <= 5'h0;
      trig_out <= 1'b0;
    end else begin
      // prescaler divides by psc plus one
      psc_cnt <= (sync_rst | wr_psc | (run & psc_hit)) ? 16'h0
               : (run & ~enc_on) ? psc_cnt + 16'h1 : psc_cnt;
      cnt <= sync_rst ? 32'h0 : wr_cnt ? (merge(cnt, w_q, strb_q) & CMASK) : next_cnt;
      cdir <= sync_rst ? 1'b0 : next_cdir;
      moved <= step;
      status <= next_status;
      irq <= |(next_status & next_mask);
      dma_req <= events & dmaen;
      // update drives the trigger and dac line
      trig_out <= uev;
    end
  end

  for (genvar i = 0; i < 4; i++) begin : g_ch
    mcpt_chan u_chan (
      .clk(sys_clk),
      .rst_n(rst_n),
      .active(i < NCH),
      .mode(ccmode[i*mcpt_pkg::CCM_W+:2]),
      .pol(ccmode[i*mcpt_pkg::CCM_W+mcpt_pkg::CCM_POL]),
      .cnt(cnt),
      .moved(moved),
      .in_lvl(ch_s2[i]),
      .wr_ccr(wr_go && (aw_q == mcpt_pkg::OFS_CCR0 + 8'(4 * i))),
      .wdata(merge(ccr[i], w_q, strb_q)),
      .ccr(ccr[i]),
      .oc(oc[i]),
      .ev(cc_ev[i])
    );
  end

  for (genvar i = 0; i < 3; i++) begin : g_dt
    wire comp = i < NCOMP;
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        dt_cnt[i] <= 8'h0;
        oc_prev[i] <= 1'b0;
        out_n[i] <= 1'b0;
      end else begin
        oc_prev[i] <= oc[i];
        // dead time restarts on every edge of the reference
        dt_cnt[i] <= (oc[i] != oc_prev[i]) ? deadt : (dt_cnt[i] != 8'h0) ? dt_cnt[i] - 8'h1 : 8'h0;
        // force inactive so power switches turn off
        out_n[i] <= comp && !frozen && !oc[i] && (oc[i] == oc_prev[i]) && dt_cnt[i] == 8'h0;
      end
    end
  end

  for (genvar i = 0; i < 4; i++) begin : g_outp
    wire comp = i < NCOMP;
    wire gap = (i < 3) ? ((oc[i] != oc_prev[i % 3]) || dt_cnt[i % 3] != 8'h0) : 1'b0;
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        out_p[i] <= 1'b0;
      end else begin
        // high side waits out the dead time
        out_p[i] <= !frozen && oc[i] && !(comp && gap);
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  irq_level_a: assert property (irq == |(status & mask))
    else $error("irq does not follow masked status");
  up_reload_a: assert property (step && !down && at_top && cms == 2'h0 && !sync_rst
      && !wr_cnt |=> cnt == 32'h0 && status[mcpt_pkg::STAT_UIF])
    else $error("no reload at top");
  down_reload_a: assert property (step && down && at_zero && cms == 2'h0 && !sync_rst
      && !wr_cnt && !enc_on |=> cnt == $past(arr_m))
    else $error("no reload at zero");
  psc_hold_a: assert property (run && !enc_on && !psc_hit && !sync_rst && !wr_cnt
      |=> $stable(cnt))
    else $error("counter moved between prescaler ticks");
  enc_count_a: assert property (enc_on && run && enc_step && enc_up && !at_top
      && !sync_rst && !wr_cnt |=> cnt == $past(cnt) + 32'h1)
    else $error("encoder step not counted");
  dead_gap_a: assert property (NCOMP > 0 && oc[0] != oc_prev[0] && deadt != 8'h0
      |=> !out_p[0] && !out_n[0] ##1 !out_p[0] && !out_n[0])
    else $error("dead time not inserted");
  halt_off_a: assert property (frozen |=> out_p == 4'h0 && out_n == 3'h0)
    else $error("outputs active during halt");
  dma_upd_a: assert property (uev && dmaen[0] |=> dma_req[0])
    else $error("update dma request missing");
  trig_rst_a: assert property (sync_rst && !wr_cnt |=> cnt == 32'h0 && trig_out)
    else $error("trigger reset not applied");

endmodule : mcpt_timer
